// ==== sscm_pkg.sv ====
/*
  Constants, field layouts and request carrier for the socket status-change mask block.
  Assumes a host-side register port with one-cycle read and write strobes.
*/
package sscm_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_EVENT       = 8'h00;
    localparam logic [7:0]  OFS_MASK        = 8'h04;
    localparam logic [7:0]  OFS_LIVE        = 8'h08;
    localparam logic [7:0]  OFS_FORCE       = 8'h0c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          BIT_CARD_STS    = 0;
    localparam int          BIT_DET_ONE     = 1;
    localparam int          BIT_DET_TWO     = 2;
    localparam int          BIT_POWER       = 3;
    localparam int          BIT_16BIT       = 4;
    localparam int          BIT_CARDBUS     = 5;
    localparam int          BIT_VCARD_LO    = 10;
    localparam int          BIT_VCARD_HI    = 13;
    localparam int          BIT_VSOCK_LO    = 28;
    localparam int          BIT_VSOCK_HI    = 31;
    localparam int          NUM_EVENTS      = 4;
    localparam int          NUM_VCARD       = 4;
    localparam int          NUM_PINS        = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  MASK_RESET      = 4'h0;
    localparam logic [3:0]  EVENT_RESET     = 4'h0;
    localparam logic [3:0]  VSOCK_RESET     = 4'h3;
    localparam logic [3:0]  VCARD_RESET     = 4'h0;
    localparam logic [1:0]  DET_ENABLE      = 2'h3;
    localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;

    // ------------------------------------------------------------
    // Request carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } sscm_req_t;

endpackage : sscm_pkg

// ==== sscm_sync.sv ====
/*
  Two-flop synchroniser for the card socket pins.
  Assumes pins are asynchronous to clk_sys; output is safe to read.
*/
`timescale 1ns/100ps
module sscm_sync #(
    parameter int W = 3
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // ------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    meta_ff[g] <= 1'b0;
                    sync_ff[g] <= 1'b0;
                end else if (ce) begin
                    meta_ff[g] <= async_in[g];
                    sync_ff[g] <= meta_ff[g];
                end
            end
        end
    endgenerate

    assign sync_out = sync_ff;

endmodule : sscm_sync

// ==== sscm_core.sv ====
/*
  Socket event flags, interrupt mask, present-state view and interrupt request.
  Assumes host register strobes on clk_sys, card pins asynchronous, and
  power, interrogation and card-type inputs from logic on clk_sys.
*/
// How it works
// [RULE1] Event flags record changes whatever the mask bits say.
// [RULE2] Mask bits 31 to 4 read zero and ignore writes.
// [RULE3] Power-change mask bit 3 gates power events onto the interrupt; resets 0.
// [RULE4] Detect mask field 2-1 enables insertion interrupts only at 11; resets 00.
// [RULE5] Card-status mask bit 0 gates card-status events; resets 0.
// [RULE6] Interrupt raised only for event types the mask enables.
// [RULE7] Present state shows live socket status and forced values.
// [RULE8] Card-type fields load only on card insertion; card-voltage loads on insertion and ORs in force-register writes.
// [RULE9] Detect pins ignored by present state during card interrogation.
// [RULE10] Power and detect flags set on state change; cleared by writing 1.
// [RULE11] Card-status flag on rising edge for CardBus, both edges for 16-bit.
// [RULE12] Software clears pending flags before unmasking interrupts.
// [RULE13] Interrupt is OR of flag AND enable, held until flags cleared.
// [RULE14] Writes to the present-state register change nothing.
`timescale 1ns/100ps
module sscm_core (
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic                 ce,
    input  wire sscm_pkg::sscm_req_t  req,
    output logic [31:0]               rdata,
    input  wire logic                 card_detect_pin_one,
    input  wire logic                 card_detect_pin_two,
    input  wire logic                 card_status_pin,
    input  wire logic                 socket_powered,
    input  wire logic                 interrogating,
    input  wire logic                 card_inserted,
    input  wire logic                 card_is_cardbus,
    input  wire logic                 card_is_16bit,
    input  wire logic [3:0]           card_voltage,
    output logic                      status_change_interrupt
);

    // ------------------------------------------------------------
    // Internal state and decode
    // ------------------------------------------------------------
    logic [2:0]  pins_sync;
    logic [3:0]  mask_ff;
    logic [3:0]  flag_ff;
    logic [3:0]  nxt_flag;
    logic [3:0]  level_ff;
    logic [3:0]  change;
    logic [3:0]  enable;
    logic [3:0]  vcard_ff;
    logic        cardbus_ff;
    logic        bit16_ff;
    logic        det_one_state;
    logic        det_two_state;
    logic        card_status_level;
    logic [31:0] live_state;
    logic [31:0] rdata_ff;
    logic        force_wr;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    function automatic logic hit(input sscm_pkg::sscm_req_t r, input logic [7:0] ofs);
        hit = (r.addr == ofs);
    endfunction : hit

    function automatic logic det_on(input logic [3:0] m);
        det_on = m[sscm_pkg::BIT_DET_TWO:sscm_pkg::BIT_DET_ONE] == sscm_pkg::DET_ENABLE;
    endfunction : det_on

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    sscm_sync #(
        .W        (sscm_pkg::NUM_PINS)
    ) u_sync (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .ce       (ce),
        .async_in ({card_status_pin, card_detect_pin_two, card_detect_pin_one}),
        .sync_out (pins_sync)
    );

    assign card_status_level = pins_sync[2];
    assign force_wr          = req.wr && hit(req, sscm_pkg::OFS_FORCE);

    // ------------------------------------------------------------
    // Present-state levels
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            level_ff <= 4'h0;
        end else if (ce) begin
            level_ff[sscm_pkg::BIT_CARD_STS] <= card_status_level;
            level_ff[sscm_pkg::BIT_POWER]    <= socket_powered;
            if (!interrogating) begin // [RULE9]
                level_ff[sscm_pkg::BIT_DET_ONE] <= pins_sync[0];
                level_ff[sscm_pkg::BIT_DET_TWO] <= pins_sync[1];
            end
        end
    end

    assign det_one_state = level_ff[sscm_pkg::BIT_DET_ONE];
    assign det_two_state = level_ff[sscm_pkg::BIT_DET_TWO];

    // ------------------------------------------------------------
    // Card type and voltage capture
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            vcard_ff   <= sscm_pkg::VCARD_RESET;
            cardbus_ff <= 1'b0;
            bit16_ff   <= 1'b0;
        end else if (ce) begin
            if (card_inserted) begin // [RULE8]
                vcard_ff   <= card_voltage;
                cardbus_ff <= card_is_cardbus;
                bit16_ff   <= card_is_16bit;
            end else if (force_wr) begin // [RULE7]
                vcard_ff   <= vcard_ff |
                    req.wdata[sscm_pkg::BIT_VCARD_HI:sscm_pkg::BIT_VCARD_LO];
            end
        end
    end

    // ------------------------------------------------------------
    // Change detection
    // ------------------------------------------------------------
    always_comb begin
        change = 4'h0;
        change[sscm_pkg::BIT_POWER]   = socket_powered != level_ff[sscm_pkg::BIT_POWER];
        change[sscm_pkg::BIT_DET_TWO] = !interrogating &&
                                        (pins_sync[1] != det_two_state);
        change[sscm_pkg::BIT_DET_ONE] = !interrogating &&
                                        (pins_sync[0] != det_one_state);
        if (cardbus_ff) begin // [RULE11]
            change[sscm_pkg::BIT_CARD_STS] = card_status_level &&
                                             !level_ff[sscm_pkg::BIT_CARD_STS];
        end else if (bit16_ff) begin // [RULE11]
            change[sscm_pkg::BIT_CARD_STS] = card_status_level !=
                                             level_ff[sscm_pkg::BIT_CARD_STS];
        end
    end

    // ------------------------------------------------------------
    // Event flags
    // ------------------------------------------------------------
    always_comb begin
        nxt_flag = flag_ff;
        if (req.wr && hit(req, sscm_pkg::OFS_EVENT)) begin
            nxt_flag = nxt_flag & ~req.wdata[sscm_pkg::NUM_EVENTS-1:0]; // [RULE10]
        end
        nxt_flag = nxt_flag | change; // [RULE1] [RULE10]
        if (force_wr) begin
            nxt_flag = nxt_flag | req.wdata[sscm_pkg::NUM_EVENTS-1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flag_ff <= sscm_pkg::EVENT_RESET;
        end else if (ce) begin
            flag_ff <= nxt_flag;
        end
    end

    // ------------------------------------------------------------
    // Mask register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mask_ff <= sscm_pkg::MASK_RESET; // [RULE3] [RULE4] [RULE5]
        end else if (ce && req.wr && hit(req, sscm_pkg::OFS_MASK)) begin
            mask_ff <= req.wdata[sscm_pkg::NUM_EVENTS-1:0]; // [RULE2]
        end
    end

    // ------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------
    always_comb begin
        enable = 4'h0;
        enable[sscm_pkg::BIT_POWER]    = mask_ff[sscm_pkg::BIT_POWER]; // [RULE3]
        enable[sscm_pkg::BIT_DET_ONE]  = det_on(mask_ff); // [RULE4]
        enable[sscm_pkg::BIT_DET_TWO]  = det_on(mask_ff); // [RULE4]
        enable[sscm_pkg::BIT_CARD_STS] = mask_ff[sscm_pkg::BIT_CARD_STS]; // [RULE5]
    end

    assign status_change_interrupt = |(flag_ff & enable); // [RULE6] [RULE13]

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        live_state = 32'h0000_0000;
        live_state[3:0] = level_ff; // [RULE7]
        live_state[sscm_pkg::BIT_16BIT]   = bit16_ff;
        live_state[sscm_pkg::BIT_CARDBUS] = cardbus_ff;
        live_state[sscm_pkg::BIT_VCARD_HI:sscm_pkg::BIT_VCARD_LO] = vcard_ff;
        live_state[sscm_pkg::BIT_VSOCK_HI:sscm_pkg::BIT_VSOCK_LO] = sscm_pkg::VSOCK_RESET;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_ff <= sscm_pkg::RDATA_RESET;
        end else if (ce && req.rd) begin
            if (hit(req, sscm_pkg::OFS_EVENT)) begin
                rdata_ff <= {28'h0000000, flag_ff};
            end else if (hit(req, sscm_pkg::OFS_MASK)) begin
                rdata_ff <= {28'h0000000, mask_ff}; // [RULE2]
            end else if (hit(req, sscm_pkg::OFS_LIVE)) begin
                rdata_ff <= live_state; // [RULE14]
            end else begin
                rdata_ff <= sscm_pkg::RDATA_RESET;
            end
        end
    end

    assign rdata = rdata_ff;

endmodule : sscm_core

// ==== sscm_card.sv ====
/*
  PC Card partner model driving the socket detect and status pins.
  Assumes present and sts_lvl are driven by the bench on clk_sys.
*/
`timescale 1ns/100ps
module sscm_card (
    input  wire logic present,
    input  wire logic sts_lvl,
    output logic      detect_one,
    output logic      detect_two,
    output logic      status_pin
);
    // Detect pins pulled high while the socket is empty
    assign detect_one = !present;
    assign detect_two = !present;
    assign status_pin = present & sts_lvl;
endmodule : sscm_card

// ==== sscm_core_chk.sv ====
/*
  Port assertions for sscm_core, bound at the foot of this file.
  Assumes mask follows the strobe port writes; card fields load on card_inserted, voltage also ORs force writes.
*/
`timescale 1ns/100ps
module sscm_core_chk (
    input wire logic                clk_sys,
    input wire logic                rst,
    input wire logic                ce,
    input wire sscm_pkg::sscm_req_t req,
    input wire logic [31:0]         rdata,
    input wire logic                card_detect_pin_one,
    input wire logic                card_status_pin,
    input wire logic                socket_powered,
    input wire logic                interrogating,
    input wire logic                card_inserted,
    input wire logic                card_is_cardbus,
    input wire logic                card_is_16bit,
    input wire logic [3:0]          card_voltage,
    input wire logic                status_change_interrupt
);
    logic [3:0] mask_ff;
    logic [3:0] vc_ff;
    logic [1:0] typ_ff;
    wire        tk_wr = ce && req.wr;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) mask_ff <= 4'h0;
        else if (tk_wr && req.addr == 8'h04) mask_ff <= req.wdata[3:0];
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) vc_ff <= 4'h0;
        else if (ce && card_inserted) vc_ff <= card_voltage;
        else if (tk_wr && req.addr == 8'h0c) vc_ff <= vc_ff | req.wdata[13:10];
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) typ_ff <= 2'h0;
        else if (ce && card_inserted) typ_ff <= {card_is_cardbus, card_is_16bit};
    end
    // ----
    // Assertions
    // ----
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_mask_rd;
        ce && req.rd && req.addr == 8'h04 |=> rdata == {28'h0, $past(mask_ff)};
    endproperty
    a_mask_rd: assert property (p_mask_rd) else $error("mask readback wrong");
    property p_live_rd;
        ce && req.rd && req.addr == 8'h08
        |=> rdata[31:4] == {4'h3, 14'h0, $past(vc_ff), 4'h0, $past(typ_ff)};
    endproperty
    a_live_rd: assert property (p_live_rd) else $error("live state wrong");
    property p_no_en;
        !(mask_ff[3] || mask_ff[0] || mask_ff[2:1] == 2'h3) |-> !status_change_interrupt;
    endproperty
    a_no_en: assert property (p_no_en) else $error("irq while all masked");
    property p_hold;
        status_change_interrupt && !tk_wr |=> status_change_interrupt;
    endproperty
    a_hold: assert property (p_hold) else $error("irq dropped alone");
    property p_pwr;
        ce && mask_ff[3] && $changed(socket_powered) |-> ##[0:2] status_change_interrupt;
    endproperty
    a_pwr: assert property (p_pwr) else $error("power irq missing");
    property p_sts_r;
        ce && mask_ff[0] && typ_ff[1] && $rose(card_status_pin)
        |-> ##[1:5] status_change_interrupt;
    endproperty
    a_sts_r: assert property (p_sts_r) else $error("status rise irq missing");
    property p_sts_f;
        ce && mask_ff[0] && typ_ff == 2'h1 && $fell(card_status_pin)
        |-> ##[1:5] status_change_interrupt;
    endproperty
    a_sts_f: assert property (p_sts_f) else $error("status fall irq missing");
    property p_det;
        ce && mask_ff[2:1] == 2'h3 && !interrogating && $changed(card_detect_pin_one)
        |-> ##[1:5] status_change_interrupt;
    endproperty
    a_det: assert property (p_det) else $error("detect irq missing");
    c_up: cover property ($rose(status_change_interrupt));
    c_down: cover property ($fell(status_change_interrupt));
    c_live: cover property (ce && req.rd && req.addr == 8'h08);
endmodule : sscm_core_chk

bind sscm_core sscm_core_chk u_chk (.clk_sys(clk_sys), .rst(rst), .ce(ce), .req(req),
    .rdata(rdata), .card_detect_pin_one(card_detect_pin_one),
    .card_status_pin(card_status_pin), .socket_powered(socket_powered),
    .interrogating(interrogating), .card_inserted(card_inserted),
    .card_is_cardbus(card_is_cardbus), .card_is_16bit(card_is_16bit),
    .card_voltage(card_voltage), .status_change_interrupt(status_change_interrupt));

// ==== sscm_core_tb.sv ====
/*
  Self-checking bench for sscm_core with the card partner model.
  Assumes sscm_pkg, sscm_core, sscm_card and the checker compile first.
*/
`timescale 1ns/100ps
module sscm_core_tb;
    logic                clk_sys = 1'b0;
    logic                rst = 1'b1;
    logic                ce = 1'b1;
    sscm_pkg::sscm_req_t req = '0;
    logic [31:0]         rdata;
    logic [31:0]         d;
    logic                p1, p2, sp, irq;
    logic                pwr = 1'b0, intg = 1'b0, ins = 1'b0, cb = 1'b0, b16 = 1'b0;
    logic                present = 1'b0, sts = 1'b0;
    logic [3:0]          vc = 4'h0;
    int                  miscompares = 0, checked = 0;
    always #4 clk_sys = ~clk_sys;
    sscm_card card (.present(present), .sts_lvl(sts), .detect_one(p1),
        .detect_two(p2), .status_pin(sp));
    sscm_core dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .req(req), .rdata(rdata),
        .card_detect_pin_one(p1), .card_detect_pin_two(p2), .card_status_pin(sp),
        .socket_powered(pwr), .interrogating(intg), .card_inserted(ins),
        .card_is_cardbus(cb), .card_is_16bit(b16), .card_voltage(vc),
        .status_change_interrupt(irq));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        req <= '{1'b1, 1'b0, a, v};
        @(posedge clk_sys);
        req <= '0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        req <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clk_sys);
        req <= '0;
        #1 d = rdata;
    endtask : rd
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask : cmp
    task automatic ins_card(input logic c, input logic b, input logic [3:0] v);
        @(posedge clk_sys);
        ins <= 1'b1;
        cb <= c;
        b16 <= b;
        vc <= v;
        @(posedge clk_sys);
        ins <= 1'b0;
        intg <= 1'b0;
    endtask : ins_card
    // ----
    // Scenarios
    // ----
    task automatic t_regs();
        rd(8'h04);
        cmp("mask reset", 32'h0, d);
        wr(8'h04, 32'hffff_fff0);
        rd(8'h04);
        cmp("mask upper", 32'h0, d);
        wr(8'h08, 32'hffff_ffff);
        rd(8'h08);
        cmp("live ro", 32'h3000_0000, d & 32'hffff_fff0);
    endtask : t_regs
    task automatic t_pwr();
        wr(8'h00, 32'hf);
        @(posedge clk_sys) pwr <= 1'b1;
        cyc(3);
        rd(8'h00);
        cmp("pwr flag", 32'h8, d);
        cmp("irq masked", 32'h0, irq);
        wr(8'h04, 32'h8);
        cmp("irq pwr", 32'h1, irq);
        wr(8'h00, 32'h8);
        cmp("irq cleared", 32'h0, irq);
        @(posedge clk_sys) pwr <= 1'b0;
        cyc(2);
        cmp("irq pwr fall", 32'h1, irq);
        wr(8'h00, 32'h8);
        cmp("irq pwr clr", 32'h0, irq);
    endtask : t_pwr
    task automatic t_det();
        wr(8'h04, 32'h6);
        @(posedge clk_sys) present <= 1'b1;
        cyc(5);
        cmp("irq det", 32'h1, irq);
        rd(8'h00);
        cmp("det flags", 32'h6, d);
        wr(8'h00, 32'hf);
        wr(8'h04, 32'h2);
        @(posedge clk_sys) present <= 1'b0;
        cyc(5);
        cmp("irq det 01", 32'h0, irq);
        wr(8'h00, 32'hf);
    endtask : t_det
    task automatic t_card();
        @(posedge clk_sys) intg <= 1'b1;
        @(posedge clk_sys) present <= 1'b1;
        cyc(5);
        rd(8'h00);
        cmp("intg flags", 32'h0, d);
        rd(8'h08);
        cmp("intg det", 32'h6, d & 32'h6);
        ins_card(1'b1, 1'b0, 4'h5);
        rd(8'h08);
        cmp("card fields", 32'h3000_1420, d & 32'hffff_fff0);
        wr(8'h0c, 32'h800);
        rd(8'h08);
        cmp("forced vcard", 32'h3000_1c20, d & 32'hffff_fff0);
        wr(8'h00, 32'hf);
        wr(8'h04, 32'h1);
        @(posedge clk_sys) sts <= 1'b1;
        cyc(5);
        cmp("irq sts rise", 32'h1, irq);
        wr(8'h00, 32'hf);
        @(posedge clk_sys) sts <= 1'b0;
        cyc(5);
        rd(8'h00);
        cmp("cb fall", 32'h0, d);
        ins_card(1'b0, 1'b1, 4'h5);
        @(posedge clk_sys) sts <= 1'b1;
        cyc(5);
        wr(8'h00, 32'hf);
        @(posedge clk_sys) sts <= 1'b0;
        cyc(5);
        cmp("irq 16bit fall", 32'h1, irq);
    endtask : t_card
    task automatic print_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_pwr();
        t_det();
        t_card();
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        print_verdict();
    end
endmodule : sscm_core_tb
